// [rtl/gdpt_top.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Phase A trip codes register, reset 0x99
// - Four-bit code picks one of sixteen trips
// - Phase B trip codes register, reset 0x99
// - Phase C trip codes register, reset 0x99
// - Timing register at 0x0C, reset 0x2F
// - Float bit turns all drivers Hi-Z
// - Retry wait of 2, 4, 6, 8 ms
// - Dead time 500 to 4000 ns
// - Timeout bit caps peak drive at 20 us
// - Low current codes force timeout bit on
// - Peak drive period 500 to 3000 ns
// - Locked code 110b blocks register writes
module gdpt_top #(
    parameter int MS_CYCLES = gdpt_pkg::MS_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic [2:0]  write_lock_code_in,
    input  wire logic [23:0] gate_source_current_code_in,
    input  wire logic [2:0]  pwm_high_in,
    input  wire logic [2:0]  pwm_low_in,
    input  wire logic        overcurrent_in,
    output logic      [2:0]  gate_high_out,
    output logic      [2:0]  gate_low_out,
    output logic      [2:0]  gate_high_oe_out,
    output logic      [2:0]  gate_low_oe_out,
    output logic      [2:0]  peak_current_out,
    output logic      [11:0] trip_level_low_out,
    output logic      [11:0] trip_level_high_out,
    output logic             fault_recovery_wait_out,
    output logic             gate_drive_timeout_en_out
);
    localparam int CW = gdpt_pkg::CW;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pwm_h_meta;
    logic [2:0] pwm_h_sync;
    logic [2:0] pwm_l_meta;
    logic [2:0] pwm_l_sync;
    logic       oc_meta;
    logic       oc_sync;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pwm_h_meta <= 3'h0;
            pwm_h_sync <= 3'h0;
            pwm_l_meta <= 3'h0;
            pwm_l_sync <= 3'h0;
            oc_meta    <= 1'b0;
            oc_sync    <= 1'b0;
        end else begin
            pwm_h_meta <= pwm_high_in;
            pwm_h_sync <= pwm_h_meta;
            pwm_l_meta <= pwm_low_in;
            pwm_l_sync <= pwm_l_meta;
            oc_meta    <= overcurrent_in;
            oc_sync    <= oc_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bank
    gdpt_cfg_if cfg ();
    logic [5:0] low_code;

    for (genvar i = 0; i < 6; i++) begin : g_low
        assign low_code[i] =
            gate_source_current_code_in[4*i +: 4] <= gdpt_pkg::LOW_CURRENT_MAX;
    end

    // Weak gate current can stall a slow edge, so the cap stays on
    wire force_tmo = |low_code;
    wire unlocked  = write_lock_code_in != gdpt_pkg::LOCK_CODE;

    gdpt_regs u_regs (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .addr_in      (reg_addr_in),
        .wdata_in     (reg_wdata_in),
        .wr_in        (reg_wr_in),
        .rd_in        (reg_rd_in),
        .lock_code_in (write_lock_code_in),
        .force_tmo_in (force_tmo),
        .rdata_out    (reg_rdata_out),
        .cfg_out      (cfg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Field decode and timing
    wire          float_all = cfg.tim[gdpt_pkg::FLOAT_POS];
    wire [1:0]    retry_sel = cfg.tim[gdpt_pkg::RETRY_POS +: 2];
    wire [1:0]    dead_sel  = cfg.tim[gdpt_pkg::DEAD_POS +: 2];
    wire          tmo_en    = cfg.tim[gdpt_pkg::TMO_POS];
    wire [1:0]    peak_sel  = cfg.tim[gdpt_pkg::PEAK_POS +: 2];
    // Least time, rounded up
    wire [CW-1:0] dead_cyc  = CW'((gdpt_pkg::DT_NS[dead_sel] * gdpt_pkg::CLK_MHZ
                                  + 999) / 1000);
    // Drive period, rounded down
    wire [CW-1:0] peak_cyc  = CW'((gdpt_pkg::PK_NS[peak_sel] * gdpt_pkg::CLK_MHZ)
                                  / 1000);
    wire [CW-1:0] peak_eff  = (tmo_en && peak_cyc > gdpt_pkg::TMO_CYC)
                            ? gdpt_pkg::TMO_CYC : peak_cyc;

    ////////////////////////////////////////////////////////////////////////
    // Fault retry wait, counted in millisecond ticks
    logic [31:0] ms_cnt;
    logic [3:0]  wait_ms;

    wire       ms_tick     = fault_recovery_wait_out && (ms_cnt == 32'(MS_CYCLES - 1));
    wire [3:0] wait_target = 4'(({2'h0, retry_sel} + 4'h1) * gdpt_pkg::RETRY_STEP_MS);
    wire       wait_done   = ms_tick && (wait_ms == wait_target - 4'h1);
    wire       drive_en    = !float_all && !fault_recovery_wait_out && !oc_sync;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            fault_recovery_wait_out <= 1'b0;
            ms_cnt                  <= 32'h0;
            wait_ms                 <= 4'h0;
        end else if (!fault_recovery_wait_out) begin
            fault_recovery_wait_out <= oc_sync;
            ms_cnt                  <= 32'h0;
            wait_ms                 <= 4'h0;
        end else begin
            ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
            if (ms_tick) wait_ms <= wait_ms + 4'h1;
            if (wait_done) fault_recovery_wait_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Half-bridges
    logic [2:0] ph_h;
    logic [2:0] ph_l;
    logic [2:0] ph_pk;

    for (genvar p = 0; p < 3; p++) begin : g_ph
        gdpt_phase #(
            .CW (CW)
        ) u_ph (
            .ref_clk_in  (ref_clk_in),
            .reset_in    (reset_in),
            .en_in       (drive_en),
            .cmd_high_in (pwm_h_sync[p]),
            .cmd_low_in  (pwm_l_sync[p]),
            .dead_cyc_in (dead_cyc),
            .peak_cyc_in (peak_eff),
            .high_out    (ph_h[p]),
            .low_out     (ph_l[p]),
            .peak_out    (ph_pk[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            gate_high_out             <= 3'h0;
            gate_low_out              <= 3'h0;
            gate_high_oe_out          <= 3'h0;
            gate_low_oe_out           <= 3'h0;
            peak_current_out          <= 3'h0;
            trip_level_low_out        <= 12'h0;
            trip_level_high_out       <= 12'h0;
            gate_drive_timeout_en_out <= 1'b0;
        end else begin
            gate_high_out    <= ph_h & {3{drive_en}};
            gate_low_out     <= ph_l & {3{drive_en}};
            gate_high_oe_out <= {3{~float_all}};
            gate_low_oe_out  <= {3{~float_all}};
            peak_current_out <= ph_pk & {3{drive_en}};
            trip_level_low_out <= {cfg.thr_c[gdpt_pkg::THR_LO_POS +: 4],
                                   cfg.thr_b[gdpt_pkg::THR_LO_POS +: 4],
                                   cfg.thr_a[gdpt_pkg::THR_LO_POS +: 4]};
            trip_level_high_out <= {cfg.thr_c[gdpt_pkg::THR_HI_POS +: 4],
                                    cfg.thr_b[gdpt_pkg::THR_HI_POS +: 4],
                                    cfg.thr_a[gdpt_pkg::THR_HI_POS +: 4]};
            gate_drive_timeout_en_out <= tmo_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    logic [CW-1:0] off0_len;
    logic [CW-1:0] pk0_len;
    logic [31:0]   wait_len;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            off0_len <= '0;
            pk0_len  <= '0;
            wait_len <= 32'h0;
        end else begin
            if (gate_high_out[0] || gate_low_out[0]) off0_len <= '0;
            else if (off0_len != '1) off0_len <= off0_len + 1'b1;
            pk0_len  <= peak_current_out[0] ? pk0_len + 1'b1 : '0;
            wait_len <= fault_recovery_wait_out ? wait_len + 32'h1 : 32'h0;
        end
    end

    AST_RESET_DEFAULTS: assert property (
        $past(reset_in) |-> cfg.thr_a == gdpt_pkg::RST_THR
            && cfg.thr_b == gdpt_pkg::RST_THR && cfg.thr_c == gdpt_pkg::RST_THR
            && cfg.tim == gdpt_pkg::RST_TIM)
        else $error("register default missing after reset");

    AST_WR_A: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_THR_A && unlocked
            |=> cfg.thr_a == $past(reg_wdata_in))
        else $error("phase A trip register not written");

    AST_WR_B: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_THR_B && unlocked
            |=> cfg.thr_b == $past(reg_wdata_in))
        else $error("phase B trip register not written");

    AST_WR_C: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_THR_C && unlocked
            |=> cfg.thr_c == $past(reg_wdata_in))
        else $error("phase C trip register not written");

    AST_WR_TIM: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_TIM && unlocked
            |=> (cfg.tim | gdpt_pkg::TMO_MASK)
                == ($past(reg_wdata_in) | gdpt_pkg::TMO_MASK))
        else $error("timing register not written");

    AST_LOCKED: assert property (
        reg_wr_in && !unlocked |=> $stable(cfg.thr_a) && $stable(cfg.thr_b)
            && $stable(cfg.thr_c)
            && (cfg.tim & ~gdpt_pkg::TMO_MASK) == ($past(cfg.tim) & ~gdpt_pkg::TMO_MASK))
        else $error("write changed a locked register");

    AST_TRIP_A: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_THR_A && unlocked
            |-> ##2 trip_level_low_out[3:0] == $past(reg_wdata_in[7:4], 2)
                && trip_level_high_out[3:0] == $past(reg_wdata_in[3:0], 2))
        else $error("phase A trip code not applied");

    AST_FORCE_TMO: assert property (
        force_tmo |=> cfg.tim[gdpt_pkg::TMO_POS] ##1 gate_drive_timeout_en_out)
        else $error("timeout enable not forced on");

    AST_FLOAT: assert property (
        float_all |=> gate_high_oe_out == 3'h0 && gate_low_oe_out == 3'h0
            && gate_high_out == 3'h0 && gate_low_out == 3'h0)
        else $error("driver active while floating");

    AST_DEAD: assert property (
        $rose(gate_high_out[0]) || $rose(gate_low_out[0]) |-> off0_len > dead_cyc)
        else $error("dead time too short");

    AST_PEAK_LEN: assert property (
        $fell(peak_current_out[0]) && (gate_high_out[0] || gate_low_out[0])
            |-> pk0_len == peak_eff)
        else $error("peak drive period wrong");

    AST_PEAK_CAP: assert property (
        gate_drive_timeout_en_out |-> pk0_len <= gdpt_pkg::TMO_CYC)
        else $error("peak drive beyond timeout");

    AST_RETRY: assert property (
        $fell(fault_recovery_wait_out)
            |-> wait_len == 32'(wait_target) * 32'(MS_CYCLES))
        else $error("retry wait length wrong");

    AST_TRIP_B: assert property (
        reg_wr_in && reg_addr_in == gdpt_pkg::OFS_THR_B && unlocked
            |-> ##2 trip_level_low_out[7:4] == $past(reg_wdata_in[7:4], 2)
                && trip_level_high_out[7:4] == $past(reg_wdata_in[3:0], 2))
        else $error("phase B trip code not applied");

    AST_NO_SHOOT_OUT: assert property (
        (gate_high_out & gate_low_out) == 3'h0)
        else $error("both gates of a phase on");

    AST_OE_ON: assert property (
        !float_all |=> gate_high_oe_out == 3'h7 && gate_low_oe_out == 3'h7)
        else $error("drivers left floating");

    AST_FAULT_OFF: assert property (
        fault_recovery_wait_out || oc_sync
            |=> gate_high_out == 3'h0 && gate_low_out == 3'h0)
        else $error("gate on during a fault");

    AST_RD_IDLE: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data left standing");

    AST_PEAK_IN_ON: assert property (
        (peak_current_out & ~(gate_high_out | gate_low_out)) == 3'h0)
        else $error("peak current with gate off");

    AST_TMO_OUT: assert property (
        tmo_en |=> gate_drive_timeout_en_out)
        else $error("timeout enable not shown");

    ////////////////////////////////////////////////////////////////////////
    // Every half-bridge, not only phase A
    for (genvar p = 0; p < 3; p++) begin : g_chk
        logic [CW-1:0] off_len;
        logic [CW-1:0] pk_len;

        always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
                off_len <= '0;
                pk_len  <= '0;
            end else begin
                if (gate_high_out[p] || gate_low_out[p]) off_len <= '0;
                else if (off_len != '1) off_len <= off_len + 1'b1;
                pk_len <= peak_current_out[p] ? pk_len + 1'b1 : '0;
            end
        end

        AST_DEAD_PH: assert property (
            $rose(gate_high_out[p]) || $rose(gate_low_out[p]) |-> off_len > dead_cyc)
            else $error("dead time too short");

        AST_PEAK_PH: assert property (
            $fell(peak_current_out[p]) && (gate_high_out[p] || gate_low_out[p])
                |-> pk_len == peak_eff)
            else $error("peak drive period wrong");
    end

    CV_FORCE: cover property (force_tmo ##2 gate_drive_timeout_en_out);
    CV_FLOAT: cover property (float_all ##1 gate_high_oe_out == 3'h0);
    CV_RETRY: cover property ($fell(fault_recovery_wait_out));
    CV_LOCKED: cover property (reg_wr_in && !unlocked);
    CV_PEAK: cover property ($fell(peak_current_out[0]) && gate_high_out[0]);
endmodule

// [rtl/gdpt_pkg.sv]
package gdpt_pkg;
    // Register port
    localparam int         AW = 8;
    localparam int         DW = 8;
    localparam logic [7:0] OFS_THR_A = 8'h09;
    localparam logic [7:0] OFS_THR_B = 8'h0A;
    localparam logic [7:0] OFS_THR_C = 8'h0B;
    localparam logic [7:0] OFS_TIM   = 8'h0C;
    localparam logic [7:0] RST_THR   = 8'h99;
    localparam logic [7:0] RST_TIM   = 8'h2F;
    localparam logic [7:0] RD_NONE   = 8'h00;
    // Field positions
    localparam int         THR_LO_POS = 4;
    localparam int         THR_HI_POS = 0;
    localparam int         FLOAT_POS  = 7;
    localparam int         RETRY_POS  = 5;
    localparam int         DEAD_POS   = 3;
    localparam int         TMO_POS    = 2;
    localparam int         PEAK_POS   = 0;
    localparam logic [7:0] TMO_MASK   = 8'h04;
    localparam logic [2:0] LOCK_CODE  = 3'h6;
    localparam logic [3:0] LOW_CURRENT_MAX = 4'h3;
    // Timing
    localparam int         CLK_MHZ = 100;
    localparam int         CW      = 12;
    localparam int         DT_NS [4] = '{500, 1000, 2000, 4000};
    localparam int         PK_NS [4] = '{500, 1000, 2000, 3000};
    localparam int         TMO_US  = 20;
    localparam logic [11:0] TMO_CYC = 12'(TMO_US * CLK_MHZ);
    localparam int         MS_CYC  = 1000 * CLK_MHZ;
    localparam logic [3:0] RETRY_STEP_MS = 4'h2;

    typedef enum logic [1:0] {PH_OFF, PH_DEAD, PH_HIGH, PH_LOW} gdpt_ph_e;
endpackage

// [rtl/gdpt_cfg_if.sv]
`timescale 1ns/1ns
interface gdpt_cfg_if;
    logic [7:0] thr_a;
    logic [7:0] thr_b;
    logic [7:0] thr_c;
    logic [7:0] tim;
    modport src (output thr_a, output thr_b, output thr_c, output tim);
    modport dst (input thr_a, input thr_b, input thr_c, input tim);
endinterface

// [rtl/gdpt_regs.sv]
`timescale 1ns/1ns
module gdpt_regs (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [2:0] lock_code_in,
    input  wire logic       force_tmo_in,
    output logic      [7:0] rdata_out,
    gdpt_cfg_if.src         cfg_out
);
    wire       unlocked = lock_code_in != gdpt_pkg::LOCK_CODE;
    wire       wr_ok    = wr_in & unlocked;
    wire       wr_a     = wr_ok & (addr_in == gdpt_pkg::OFS_THR_A);
    wire       wr_b     = wr_ok & (addr_in == gdpt_pkg::OFS_THR_B);
    wire       wr_c     = wr_ok & (addr_in == gdpt_pkg::OFS_THR_C);
    wire       wr_t     = wr_ok & (addr_in == gdpt_pkg::OFS_TIM);
    wire [7:0] next_tim = (wr_t ? wdata_in : cfg_out.tim)
                        | (force_tmo_in ? gdpt_pkg::TMO_MASK : 8'h00);
    wire [7:0] next_rdata =
        (addr_in == gdpt_pkg::OFS_THR_A) ? cfg_out.thr_a :
        (addr_in == gdpt_pkg::OFS_THR_B) ? cfg_out.thr_b :
        (addr_in == gdpt_pkg::OFS_THR_C) ? cfg_out.thr_c :
        (addr_in == gdpt_pkg::OFS_TIM)   ? cfg_out.tim   : gdpt_pkg::RD_NONE;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cfg_out.thr_a <= gdpt_pkg::RST_THR;
            cfg_out.thr_b <= gdpt_pkg::RST_THR;
            cfg_out.thr_c <= gdpt_pkg::RST_THR;
            cfg_out.tim   <= gdpt_pkg::RST_TIM;
            rdata_out     <= 8'h00;
        end else begin
            if (wr_a) cfg_out.thr_a <= wdata_in;
            if (wr_b) cfg_out.thr_b <= wdata_in;
            if (wr_c) cfg_out.thr_c <= wdata_in;
            cfg_out.tim <= next_tim;
            rdata_out   <= rd_in ? next_rdata : 8'h00;
        end
    end

    AST_RD_TIM: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rd_in && addr_in == gdpt_pkg::OFS_TIM |=> rdata_out == $past(cfg_out.tim))
        else $error("timing register read back wrong");
endmodule

// [rtl/gdpt_phase.sv]
`timescale 1ns/1ns
module gdpt_phase #(
    parameter int CW = 12
) (
    input  wire logic          ref_clk_in,
    input  wire logic          reset_in,
    input  wire logic          en_in,
    input  wire logic          cmd_high_in,
    input  wire logic          cmd_low_in,
    input  wire logic [CW-1:0] dead_cyc_in,
    input  wire logic [CW-1:0] peak_cyc_in,
    output logic               high_out,
    output logic               low_out,
    output logic               peak_out
);
    gdpt_pkg::gdpt_ph_e st;
    logic [CW-1:0]      dcnt;
    logic [CW-1:0]      pcnt;
    logic               tgt_high;

    // Both commands at once means both off
    wire want_h  = en_in & cmd_high_in & ~cmd_low_in;
    wire want_l  = en_in & cmd_low_in & ~cmd_high_in;
    wire want_on = want_h | want_l;
    wire on      = (st == gdpt_pkg::PH_HIGH) | (st == gdpt_pkg::PH_LOW);

    assign high_out = st == gdpt_pkg::PH_HIGH;
    assign low_out  = st == gdpt_pkg::PH_LOW;
    assign peak_out = on & (pcnt != '0);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st       <= gdpt_pkg::PH_OFF;
            dcnt     <= '0;
            pcnt     <= '0;
            tgt_high <= 1'b0;
        end else begin
            if (on && pcnt != '0) pcnt <= pcnt - 1'b1;
            case (st)
                gdpt_pkg::PH_OFF: begin
                    if (want_on) begin
                        st       <= gdpt_pkg::PH_DEAD;
                        dcnt     <= dead_cyc_in;
                        tgt_high <= want_h;
                    end
                end
                gdpt_pkg::PH_DEAD: begin
                    if (!want_on || want_h != tgt_high) begin
                        st <= gdpt_pkg::PH_OFF;
                    end else if (dcnt <= 1) begin
                        st   <= tgt_high ? gdpt_pkg::PH_HIGH : gdpt_pkg::PH_LOW;
                        pcnt <= peak_cyc_in;
                    end else begin
                        dcnt <= dcnt - 1'b1;
                    end
                end
                gdpt_pkg::PH_HIGH: if (!want_h) st <= gdpt_pkg::PH_OFF;
                gdpt_pkg::PH_LOW:  if (!want_l) st <= gdpt_pkg::PH_OFF;
                default: st <= gdpt_pkg::PH_OFF;
            endcase
        end
    end

    AST_NO_SHOOT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !(high_out && low_out))
        else $error("both switches of a half-bridge on");
endmodule

// [test/gdpt_host.sv]
`timescale 1ns/1ns
module gdpt_host (
    input  wire logic       ref_clk_in,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle strobe; idle address and data show inverted values so stale data never looks valid
    task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= is_wr;
        rd_out    <= ~is_wr;
        @(posedge ref_clk_in);
        addr_out  <= ~a;
        wdata_out <= ~d;
        wr_out    <= 1'b0;
        rd_out    <= 1'b0;
    endtask
endmodule

// [test/test_gate_driver_protection_timing_regs.sv]
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        $display("Error %s expected %0h seen %0h", nm, exp, got); \
        fail_count++; \
    end \
end
module test_gate_driver_protection_timing_regs;
    localparam int MSC = 10;
    logic        ref_clk_in;
    logic        reset_in;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata_out;
    logic [2:0]  lock_code;
    logic [23:0] cur_code;
    logic [2:0]  pwm_high;
    logic [2:0]  pwm_low;
    logic        overcurrent;
    logic [2:0]  gate_high_out;
    logic [2:0]  gate_low_out;
    logic [2:0]  gate_high_oe_out;
    logic [2:0]  gate_low_oe_out;
    logic [2:0]  peak_current_out;
    logic [11:0] trip_lo_out;
    logic [11:0] trip_hi_out;
    logic        retry_wait_out;
    logic        tmo_en_out;
    logic [7:0]  exp_q[$];
    logic [7:0]  exp_v;
    logic        rd_seen = 1'b0;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          seed = 45;

    gdpt_host host (.ref_clk_in(ref_clk_in), .addr_out(reg_addr), .wdata_out(reg_wdata),
        .wr_out(reg_wr), .rd_out(reg_rd));

    gdpt_top #(.MS_CYCLES(MSC)) uut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata_out), .write_lock_code_in(lock_code),
        .gate_source_current_code_in(cur_code), .pwm_high_in(pwm_high),
        .pwm_low_in(pwm_low), .overcurrent_in(overcurrent), .gate_high_out(gate_high_out),
        .gate_low_out(gate_low_out), .gate_high_oe_out(gate_high_oe_out),
        .gate_low_oe_out(gate_low_oe_out), .peak_current_out(peak_current_out),
        .trip_level_low_out(trip_lo_out), .trip_level_high_out(trip_hi_out),
        .fault_recovery_wait_out(retry_wait_out), .gate_drive_timeout_en_out(tmo_en_out));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk_in) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("reg_rdata_out", exp_v, reg_rdata_out)
        end
        rd_seen <= reg_rd;
    end

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fail_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v [3];
        int         k;
        int         n;
        int         dt;
        int         pk;
        reset_in    = 1'b1;
        lock_code   = 3'h3;
        cur_code    = 24'hFFFFFF;
        pwm_high    = 3'h0;
        pwm_low     = 3'h0;
        overcurrent = 1'b0;
        repeat (6) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        for (k = 0; k < 4; k++) begin
            rd_chk(8'(gdpt_pkg::OFS_THR_A + k), (k == 3) ? gdpt_pkg::RST_TIM : gdpt_pkg::RST_THR);
        end
        rd_chk(8'h0D, 8'h00);
        @(negedge ref_clk_in);
        `CHK("trip low", 12'h999, trip_lo_out)
        `CHK("trip high", 12'h999, trip_hi_out)
        `CHK("timeout en", 1'b1, tmo_en_out)
        for (k = 0; k < 3; k++) begin
            v[k] = 8'($random(seed));
            wr_reg(8'(gdpt_pkg::OFS_THR_A + k), v[k]);
        end
        wr_reg(8'h08, 8'h00);
        for (k = 0; k < 3; k++) begin
            rd_chk(8'(gdpt_pkg::OFS_THR_A + k), v[k]);
        end
        @(negedge ref_clk_in);
        `CHK("trip low", {v[2][7:4], v[1][7:4], v[0][7:4]}, trip_lo_out)
        `CHK("trip high", {v[2][3:0], v[1][3:0], v[0][3:0]}, trip_hi_out)
        @(posedge ref_clk_in);
        lock_code <= gdpt_pkg::LOCK_CODE;
        wr_reg(gdpt_pkg::OFS_THR_B, ~v[1]);
        rd_chk(gdpt_pkg::OFS_THR_B, v[1]);
        lock_code <= 3'h3;
        wr_reg(gdpt_pkg::OFS_THR_B, ~v[1]);
        rd_chk(gdpt_pkg::OFS_THR_B, ~v[1]);
        // Low gate-current code must win over a written zero
        cur_code <= 24'h444444 | 24'($random(seed));
        wr_reg(gdpt_pkg::OFS_TIM, 8'h2B);
        repeat (3) @(negedge ref_clk_in);
        `CHK("timeout en", 1'b0, tmo_en_out)
        @(posedge ref_clk_in);
        n = {$random(seed)} % 6;
        cur_code[4*n +: 4] <= 4'($random(seed)) & gdpt_pkg::LOW_CURRENT_MAX;
        repeat (3) @(negedge ref_clk_in);
        `CHK("timeout en", 1'b1, tmo_en_out)
        @(posedge ref_clk_in);
        cur_code <= 24'hFFFFFF;
        wr_reg(gdpt_pkg::OFS_TIM, gdpt_pkg::RST_TIM);
        repeat (3) @(negedge ref_clk_in);
        `CHK("timeout en", 1'b1, tmo_en_out)
        for (k = 0; k < 4; k++) begin
            wr_reg(gdpt_pkg::OFS_TIM, 8'(k * 8 + (3 - k)) | gdpt_pkg::TMO_MASK);
            dt = gdpt_pkg::DT_NS[k] / 10;
            pk = gdpt_pkg::PK_NS[3 - k] / 10;
            if (k[0]) pwm_low[k % 3] <= 1'b1;
            else pwm_high[k % 3] <= 1'b1;
            n = 0;
            do begin
                @(negedge ref_clk_in);
                n++;
            end while (n < 1000 && (k[0] ? gate_low_out[k % 3] : gate_high_out[k % 3]) !== 1'b1);
            `CHK("dead time in range", 1'b1, n > dt && n <= dt + 8)
            n = 0;
            while (n < 1000 && peak_current_out[k % 3] === 1'b1) begin
                @(negedge ref_clk_in);
                n++;
            end
            `CHK("peak width", pk, n)
            @(posedge ref_clk_in);
            pwm_high <= 3'h0;
            pwm_low  <= 3'h0;
            repeat (10) @(posedge ref_clk_in);
        end
        // Phase C gets both commands and must stay off
        pwm_low  <= 3'h6;
        pwm_high <= 3'h4;
        repeat (450) @(negedge ref_clk_in);
        `CHK("gates", 6'h02, {gate_high_out, gate_low_out})
        wr_reg(gdpt_pkg::OFS_TIM, gdpt_pkg::RST_TIM | 8'h80);
        repeat (3) @(negedge ref_clk_in);
        `CHK("output enables", 6'h00, {gate_high_oe_out, gate_low_oe_out})
        `CHK("gates", 6'h00, {gate_high_out, gate_low_out})
        @(posedge ref_clk_in);
        pwm_low  <= 3'h0;
        pwm_high <= 3'h0;
        wr_reg(gdpt_pkg::OFS_TIM, gdpt_pkg::RST_TIM);
        repeat (3) @(negedge ref_clk_in);
        `CHK("output enables", 6'h3F, {gate_high_oe_out, gate_low_oe_out})
        // Short fault pulse so the wait is not restarted by a lingering fault
        for (k = 0; k < 4; k++) begin
            wr_reg(gdpt_pkg::OFS_TIM, 8'(k * 32) | 8'h07);
            overcurrent <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            overcurrent <= 1'b0;
            n = 0;
            while (n < 50 && retry_wait_out !== 1'b1) begin
                @(negedge ref_clk_in);
                n++;
            end
            n = 0;
            while (n < 400 && retry_wait_out === 1'b1) begin
                @(negedge ref_clk_in);
                n++;
            end
            dt = (k + 1) * 2 * MSC;
            `CHK("retry wait", 1'b1, n >= dt - 2 && n <= dt + 2)
        end
        repeat (4) @(posedge ref_clk_in);
        give_verdict();
    end
endmodule
